// *** design/adc_config_register_bank.v ***
// Function
// - Power down stops core, references, output buffers
// - Low-rate mode bit selects sample-rate range
// - Format bit picks two's complement or binary
// - Pattern code replaces samples on data outputs
// - Toggle code alternates bits in time, space
// - Ramp code counts 0x0000 to 0x3FFF
// - Custom code drives programmed 14-bit word
// - Two registers hold custom word halves
// - Gain field in 1 dB steps, 0 dB default
// - Clock buffer gain field, gain 1 default
// - Soft reset bit restores all defaults
// - Interface field picks DDR LVDS or CMOS
// - Reference bit picks internal or external
// - Power scaling field, highest rate default
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "adc_cfg_defs.vh"

module adc_config_register_bank (
    input wire aclk,
    input wire aresetn,
    input wire [`ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [`DATA_W-1:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [`DATA_W-1:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [`SAMPLE_W-1:0] sample_in,
    output wire [`SAMPLE_W-1:0] data_out,
    output wire data_oe,
    output wire core_power_down,
    output wire low_speed_mode,
    output wire sample_encoding_select,
    output wire [3:0] analog_gain,
    output wire gain_code_valid,
    output wire [5:0] clk_buf_gain,
    output wire clk_gain_code_valid,
    output wire cmos_mode,
    output wire external_reference,
    output wire [2:0] power_scale,
    output wire soft_reset_pulse
);

    // ****************************************
    // Stored fields
    // ****************************************
    reg pd_reg;
    reg low_reg;
    reg enc_reg;
    reg [2:0] pat_reg;
    reg [3:0] gain_reg;
    reg [7:0] cust_lo_reg;
    reg [5:0] cust_hi_reg;
    reg [5:0] clkg_reg;
    reg [1:0] iface_reg;
    reg ref_reg;
    reg [2:0] scale_reg;
    reg srst_pulse_reg;

    wire wr_en;
    wire [`IDX_W-1:0] wr_index;
    wire [7:0] wr_data;
    wire wr_hit;
    wire [`IDX_W-1:0] rd_index;
    reg [7:0] rd_data;
    wire rd_hit;
    wire soft_rst;
    wire any_rst;

    // ****************************************
    // Address decode
    // ****************************************
    function is_mapped;
        input [`IDX_W-1:0] idx;
        begin
            case (idx)
                `IDX_PWR_FMT,
                `IDX_PATTERN,
                `IDX_GAIN,
                `IDX_CUST_LO,
                `IDX_CUST_HI,
                `IDX_CLK_GAIN,
                `IDX_IFACE,
                `IDX_REF_SCALE: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    function wr_to;
        input [`IDX_W-1:0] target;
        begin
            wr_to = wr_en && (wr_index == target);
        end
    endfunction

    assign wr_hit = is_mapped(wr_index);
    assign rd_hit = is_mapped(rd_index);

    // Reset wins over the other fields of the same write
    assign soft_rst = wr_to(`IDX_IFACE) && wr_data[`SRST_BIT];
    assign any_rst = !aresetn || soft_rst;

    // ****************************************
    // Bus slave
    // ****************************************
    axil_port u_port (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_index(wr_index),
        .wr_data(wr_data),
        .wr_hit(wr_hit),
        .rd_index(rd_index),
        .rd_data(rd_data),
        .rd_hit(rd_hit)
    );

    // ****************************************
    // Power, speed and format
    // ****************************************
    always @(posedge aclk) begin
        if (any_rst) begin
            pd_reg <= 1'b0;
            low_reg <= 1'b0;
            enc_reg <= 1'b0;
        end else if (wr_to(`IDX_PWR_FMT)) begin
            pd_reg <= wr_data[`PD_BIT];
            low_reg <= wr_data[`LOW_BIT];
            enc_reg <= wr_data[`ENC_BIT];
        end
    end

    // ****************************************
    // Test pattern and custom word
    // ****************************************
    always @(posedge aclk) begin
        if (any_rst) begin
            pat_reg <= `PAT_NORMAL;
        end else if (wr_to(`IDX_PATTERN)) begin
            pat_reg <= wr_data[`PAT_HI:`PAT_LO];
        end
    end

    always @(posedge aclk) begin
        if (any_rst) begin
            cust_lo_reg <= 8'h00;
        end else if (wr_to(`IDX_CUST_LO)) begin
            cust_lo_reg <= wr_data;
        end
    end

    always @(posedge aclk) begin
        if (any_rst) begin
            cust_hi_reg <= 6'h00;
        end else if (wr_to(`IDX_CUST_HI)) begin
            cust_hi_reg <= wr_data[`CUST_HI_HI:0];
        end
    end

    // ****************************************
    // Analogue and clock buffer gain
    // ****************************************
    always @(posedge aclk) begin
        if (any_rst) begin
            gain_reg <= `GAIN_DEF;
        end else if (wr_to(`IDX_GAIN)) begin
            gain_reg <= wr_data[`GAIN_HI:0];
        end
    end

    always @(posedge aclk) begin
        if (any_rst) begin
            clkg_reg <= `CLKG_DEF;
        end else if (wr_to(`IDX_CLK_GAIN)) begin
            clkg_reg <= wr_data[`CLKG_HI:0];
        end
    end

    // ****************************************
    // Interface, reference and scaling
    // ****************************************
    always @(posedge aclk) begin
        if (any_rst) begin
            iface_reg <= `IFACE_DEF;
        end else if (wr_to(`IDX_IFACE)) begin
            iface_reg <= wr_data[`IFACE_HI:`IFACE_LO];
        end
    end

    always @(posedge aclk) begin
        if (any_rst) begin
            ref_reg <= 1'b0;
            scale_reg <= `SCALE_DEF;
        end else if (wr_to(`IDX_REF_SCALE)) begin
            ref_reg <= wr_data[`REF_BIT];
            // Any code is stored; matching it to the rate is up to software
            scale_reg <= wr_data[`SCALE_HI:`SCALE_LO];
        end
    end

    // One-cycle flag to the analogue side after a soft reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            srst_pulse_reg <= 1'b0;
        end else begin
            srst_pulse_reg <= soft_rst;
        end
    end

    // ****************************************
    // Read back
    // ****************************************
    // Soft reset bit is self clearing and reads as zero
    always @* begin
        rd_data = 8'h00;
        case (rd_index)
            `IDX_PWR_FMT: begin
                rd_data[`PD_BIT] = pd_reg;
                rd_data[`LOW_BIT] = low_reg;
                rd_data[`ENC_BIT] = enc_reg;
            end
            `IDX_PATTERN: begin
                rd_data[`PAT_HI:`PAT_LO] = pat_reg;
            end
            `IDX_GAIN: begin
                rd_data[`GAIN_HI:0] = gain_reg;
            end
            `IDX_CUST_LO: begin
                rd_data = cust_lo_reg;
            end
            `IDX_CUST_HI: begin
                rd_data[`CUST_HI_HI:0] = cust_hi_reg;
            end
            `IDX_CLK_GAIN: begin
                rd_data[`CLKG_HI:0] = clkg_reg;
            end
            `IDX_IFACE: begin
                rd_data[`IFACE_HI:`IFACE_LO] = iface_reg;
            end
            `IDX_REF_SCALE: begin
                rd_data[`REF_BIT] = ref_reg;
                rd_data[`SCALE_HI:`SCALE_LO] = scale_reg;
            end
            default: begin
                rd_data = 8'h00;
            end
        endcase
    end

    // ****************************************
    // Data path patterns
    // ****************************************
    pattern_gen u_pattern (
        .aclk(aclk),
        .aresetn(aresetn),
        .pattern_code(pat_reg),
        .custom_word({cust_hi_reg, cust_lo_reg}),
        .straight_binary(enc_reg),
        .power_down(pd_reg),
        .sample_in(sample_in),
        .data_out(data_out),
        .data_oe(data_oe)
    );

    // ****************************************
    // Field outputs
    // ****************************************
    assign core_power_down = pd_reg;
    assign low_speed_mode = low_reg;
    assign sample_encoding_select = enc_reg;
    assign analog_gain = gain_reg;
    // Unlisted codes pass through; flags let the analogue side ignore them
    assign gain_code_valid = gain_reg[`GAIN_HI] &&
        (gain_reg <= `GAIN_MAX);
    assign clk_buf_gain = clkg_reg;
    assign clk_gain_code_valid = (clkg_reg == 6'h23) ||
        (clkg_reg == 6'h20) || (clkg_reg == 6'h26) ||
        (clkg_reg == 6'h2A) || (clkg_reg == 6'h32);
    // Codes 00 and 01 are both LVDS; 10 is treated as LVDS
    assign cmos_mode = (iface_reg == `IFACE_CMOS);
    assign external_reference = ref_reg;
    assign power_scale = scale_reg;
    assign soft_reset_pulse = srst_pulse_reg;

endmodule

// *** inc/adc_cfg_defs.vh ***
`ifndef ADC_CFG_DEFS_VH
`define ADC_CFG_DEFS_VH

// ****************************************
// Bus widths and responses
// ****************************************
`define ADDR_W 10
`define DATA_W 32
`define IDX_W 8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ****************************************
// Register indices, byte address is 4x
// ****************************************
`define IDX_PWR_FMT 8'h63
`define IDX_PATTERN 8'h65
`define IDX_GAIN 8'h68
`define IDX_CUST_LO 8'h69
`define IDX_CUST_HI 8'h6A
`define IDX_CLK_GAIN 8'h6B
`define IDX_IFACE 8'h6C
`define IDX_REF_SCALE 8'h6D

// ****************************************
// Field positions
// ****************************************
`define PD_BIT 7
`define LOW_BIT 4
`define ENC_BIT 3
`define PAT_HI 7
`define PAT_LO 5
`define GAIN_HI 3
`define CUST_HI_HI 5
`define CLKG_HI 5
`define IFACE_HI 4
`define IFACE_LO 3
`define SRST_BIT 1
`define REF_BIT 4
`define SCALE_HI 7
`define SCALE_LO 5

// ****************************************
// Reset values and codes
// ****************************************
`define GAIN_DEF 4'h8
`define GAIN_MAX 4'hE
`define CLKG_DEF 6'h20
`define IFACE_DEF 2'h0
`define IFACE_CMOS 2'h3
`define SCALE_DEF 3'h1
`define PAT_NORMAL 3'h0
`define PAT_ZEROS 3'h1
`define PAT_ONES 3'h2
`define PAT_TOGGLE 3'h3
`define PAT_RAMP 3'h4
`define PAT_CUSTOM 3'h5
`define SAMPLE_W 14
`define RAMP_START 14'h0000
`define RAMP_END 14'h3FFF
`define TOGGLE_SEED 14'h1555
`define ALL_ONES 14'h3FFF

`endif

// *** design/axil_port.v ***
`timescale 1ns/1ns
`include "adc_cfg_defs.vh"

module axil_port (
    input wire aclk,
    input wire aresetn,
    input wire [`ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [`DATA_W-1:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [`DATA_W-1:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output wire wr_en,
    output wire [`IDX_W-1:0] wr_index,
    output wire [7:0] wr_data,
    input wire wr_hit,
    output wire [`IDX_W-1:0] rd_index,
    input wire [7:0] rd_data,
    input wire rd_hit
);
    reg aw_full_reg;
    reg w_full_reg;
    reg [`IDX_W-1:0] aw_idx_reg;
    reg [7:0] w_data_reg;
    reg w_lane_reg;

    assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_index = aw_idx_reg;
    assign wr_data = w_data_reg;
    // Only byte lane 0 carries register bits
    assign wr_en = aw_full_reg && w_full_reg && !s_axi_bvalid && w_lane_reg;
    assign rd_index = s_axi_araddr[`ADDR_W-1:2];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_idx_reg <= 8'h00;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                aw_idx_reg <= s_axi_awaddr[`ADDR_W-1:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata[7:0];
                w_lane_reg <= s_axi_wstrb[0];
            end
            if (aw_full_reg && w_full_reg && !s_axi_bvalid) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_data};
            s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// *** design/pattern_gen.v ***
`timescale 1ns/1ns
`include "adc_cfg_defs.vh"

module pattern_gen (
    input wire aclk,
    input wire aresetn,
    input wire [2:0] pattern_code,
    input wire [`SAMPLE_W-1:0] custom_word,
    input wire straight_binary,
    input wire power_down,
    input wire [`SAMPLE_W-1:0] sample_in,
    output reg [`SAMPLE_W-1:0] data_out,
    output reg data_oe
);
    reg [`SAMPLE_W-1:0] ramp_reg;
    reg [`SAMPLE_W-1:0] toggle_reg;
    reg [`SAMPLE_W-1:0] data_next;

    always @(posedge aclk) begin
        if (!aresetn || pattern_code != `PAT_RAMP) begin
            ramp_reg <= `RAMP_START;
        end else if (ramp_reg == `RAMP_END) begin
            ramp_reg <= `RAMP_START;
        end else begin
            ramp_reg <= ramp_reg + 14'h0001;
        end
    end

    // Neighbouring bits differ, and each bit flips every sample
    always @(posedge aclk) begin
        if (!aresetn || pattern_code != `PAT_TOGGLE) begin
            toggle_reg <= `TOGGLE_SEED;
        end else begin
            toggle_reg <= ~toggle_reg;
        end
    end

    always @* begin
        data_next = `RAMP_START;
        case (pattern_code)
            `PAT_NORMAL: begin
                // Core gives offset binary; MSB flip for 2's complement
                data_next = straight_binary ? sample_in :
                    {~sample_in[`SAMPLE_W-1], sample_in[`SAMPLE_W-2:0]};
            end
            `PAT_ZEROS: data_next = `RAMP_START;
            `PAT_ONES: data_next = `ALL_ONES;
            `PAT_TOGGLE: data_next = toggle_reg;
            `PAT_RAMP: data_next = ramp_reg;
            `PAT_CUSTOM: data_next = custom_word;
            default: data_next = `RAMP_START;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn || power_down) begin
            data_out <= `RAMP_START;
            data_oe <= 1'b0;
        end else begin
            data_out <= data_next;
            data_oe <= 1'b1;
        end
    end
endmodule

// *** bench/adc_cfg_chk.sv ***
`timescale 1ns/1ns
`include "adc_cfg_defs.vh"
module adc_cfg_chk (
    input logic aclk,
    input logic aresetn,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic [`SAMPLE_W-1:0] data_out,
    input logic data_oe,
    input logic core_power_down,
    input logic [3:0] analog_gain,
    input logic gain_code_valid,
    input logic [5:0] clk_buf_gain,
    input logic clk_gain_code_valid,
    input logic [2:0] power_scale,
    input logic cmos_mode,
    input logic soft_reset_pulse
);
    // ********
    // Properties
    // ********
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_pd_quiet: assert property (
        core_power_down |=> !data_oe && data_out == 14'h0000)
        else $error("power down left outputs active");
    a_oe_back: assert property (
        !core_power_down [*4] |-> data_oe)
        else $error("outputs not enabled");
    a_gain_listed: assert property (
        gain_code_valid == (analog_gain >= 4'h8 && analog_gain <= 4'hE))
        else $error("gain valid flag wrong");
    a_clkg_listed: assert property (
        clk_gain_code_valid == (clk_buf_gain inside
        {6'h23, 6'h20, 6'h26, 6'h2A, 6'h32}))
        else $error("clock gain valid flag wrong");
    a_srst_dflt: assert property (
        soft_reset_pulse |-> analog_gain == `GAIN_DEF && !cmos_mode &&
        clk_buf_gain == `CLKG_DEF && power_scale == `SCALE_DEF)
        else $error("soft reset left fields set");
    a_srst_once: assert property (
        soft_reset_pulse |=> !soft_reset_pulse)
        else $error("soft reset pulse too long");
    a_wr_resp: assert property (
        wr_take |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_rd_resp: assert property (
        rd_take |=> s_axi_rvalid)
        else $error("read data late");
    a_b_block: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_r_block: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
endmodule
bind adc_config_register_bank adc_cfg_chk chk_i (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .data_out, .data_oe, .core_power_down, .analog_gain, .gain_code_valid,
    .clk_buf_gain, .clk_gain_code_valid, .power_scale, .cmos_mode,
    .soft_reset_pulse);

// *** bench/axil_host.sv ***
`timescale 1ns/1ns
`include "adc_cfg_defs.vh"
module axil_host (
    input logic aclk,
    output logic [`ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input logic s_axi_awready,
    output logic [`DATA_W-1:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [`ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [`DATA_W-1:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
    end
    // ********
    // Bus cycles
    // ********
    task automatic wr(input [7:0] i, input [7:0] d, input [3:0] s,
                      output [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (!s_axi_awready);
                s_axi_awvalid <= 1'b0;
                // Released lines do not keep a stale address
                s_axi_awaddr <= ~s_axi_awaddr;
            end
            begin
                do @(posedge aclk); while (!s_axi_wready);
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~s_axi_wdata;
            end
        join
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input [7:0] i, output [31:0] d, output [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~s_axi_araddr;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ns
`include "adc_cfg_defs.vh"
module testbench;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic [`ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [`DATA_W-1:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb, analog_gain;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, data_oe, soft_reset_pulse;
    logic [`SAMPLE_W-1:0] sample_in, data_out;
    logic core_power_down, low_speed_mode, sample_encoding_select;
    logic [5:0] clk_buf_gain;
    logic [2:0] power_scale;
    logic gain_code_valid, clk_gain_code_valid, cmos_mode, external_reference;
    int fails, checks_done, cycles, pulses;
    localparam logic [7:0] IDX [8] = '{`IDX_PWR_FMT, `IDX_PATTERN,
        `IDX_GAIN, `IDX_CUST_LO, `IDX_CUST_HI, `IDX_CLK_GAIN, `IDX_IFACE,
        `IDX_REF_SCALE};
    localparam logic [7:0] DEF [8] = '{8'h00, 8'h00, 8'h08, 8'h00, 8'h00,
        8'h20, 8'h00, 8'h20};
    localparam logic [5:0] CG [5] = '{6'h23, 6'h20, 6'h26, 6'h2A, 6'h32};
    localparam logic [2:0] PC [3] = '{3'h1, 3'h2, 3'h5};
    localparam logic [13:0] PV [3] = '{14'h0000, 14'h3FFF, 14'h3CA5};

    adc_config_register_bank dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .sample_in, .data_out, .data_oe, .core_power_down, .low_speed_mode,
        .sample_encoding_select, .analog_gain, .gain_code_valid,
        .clk_buf_gain, .clk_gain_code_valid, .cmos_mode,
        .external_reference, .power_scale, .soft_reset_pulse);
    axil_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles++;
        if (soft_reset_pulse === 1'b1)
            pulses++;
        // Ramp wrap alone takes about 16k cycles
        if (cycles == 40000) begin
            fails++;
            summarize();
        end
    end
    // ********
    // Helpers
    // ********
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s exp %h got %h", n, e, g);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task wreg(input [7:0] i, input [7:0] d);
        host.wr(i, d, 4'hF, rsp);
        chk("bresp", `RESP_OKAY, rsp);
    endtask
    task rchk(input [7:0] i, input [7:0] e);
        host.rd(i, rdv, rsp);
        chk($sformatf("reg %h", i), e, rdv);
        chk("rresp", `RESP_OKAY, rsp);
    endtask
    task summarize;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ********
    // Scenarios
    // ********
    task t_defaults;
        for (int k = 0; k < 8; k++)
            rchk(IDX[k], DEF[k]);
        chk("gain", `GAIN_DEF, analog_gain);
        chk("clk gain", `CLKG_DEF, clk_buf_gain);
        chk("scale", `SCALE_DEF, power_scale);
        chk("cmos", 0, cmos_mode);
        chk("oe", 1, data_oe);
    endtask
    task t_unmapped;
        host.rd(8'h64, rdv, rsp);
        chk("unmapped rresp", `RESP_SLVERR, rsp);
        chk("unmapped rdata", 0, rdv);
        host.wr(8'h64, 8'hFF, 4'hF, rsp);
        chk("unmapped bresp", `RESP_SLVERR, rsp);
        host.wr(`IDX_GAIN, 8'h0C, 4'hE, rsp);
        chk("strobe bresp", `RESP_OKAY, rsp);
        rchk(`IDX_GAIN, 8'h08);
    endtask
    task t_ctrl;
        wreg(`IDX_PWR_FMT, 8'h00);
        tick(2);
        chk("twos comp", 14'h0001, data_out);
        wreg(`IDX_PWR_FMT, 8'h08);
        tick(2);
        chk("straight", 14'h2001, data_out);
        chk("encoding", 1, sample_encoding_select);
        wreg(`IDX_PWR_FMT, 8'h90);
        tick(2);
        chk("power down", 1, core_power_down);
        chk("oe off", 0, data_oe);
        chk("pd data", 0, data_out);
        chk("low speed", 1, low_speed_mode);
        rchk(`IDX_PWR_FMT, 8'h90);
        wreg(`IDX_PWR_FMT, 8'h00);
        tick(4);
        chk("oe back", 1, data_oe);
        chk("low speed", 0, low_speed_mode);
    endtask
    task t_patterns;
        logic [13:0] a, b;
        wreg(`IDX_CUST_LO, 8'hA5);
        wreg(`IDX_CUST_HI, 8'h3C);
        rchk(`IDX_CUST_HI, 8'h3C);
        for (int k = 0; k < 3; k++) begin
            wreg(`IDX_PATTERN, {PC[k], 5'h00});
            tick(2);
            chk("pattern", PV[k], data_out);
        end
        wreg(`IDX_PATTERN, 8'h60);
        tick(2);
        a = data_out;
        chk("toggle seed", 1, a == 14'h1555 || a == 14'h2AAA);
        tick(1);
        chk("toggle step", 14'h3FFF, a ^ data_out);
        wreg(`IDX_PATTERN, 8'h80);
        tick(2);
        b = data_out + 14'h0001;
        tick(1);
        chk("ramp step", b, data_out);
        for (int k = 0; k < 17000 && data_out !== 14'h3FFF; k++)
            tick(1);
        tick(1);
        chk("ramp wrap", 14'h0000, data_out);
        wreg(`IDX_PATTERN, 8'h00);
    endtask
    task t_fields;
        for (int k = 8; k <= 14; k++) begin
            wreg(`IDX_GAIN, 8'(k));
            chk("gain", k, analog_gain);
            chk("gain ok", 1, gain_code_valid);
        end
        wreg(`IDX_GAIN, 8'h0F);
        chk("gain bad", 0, gain_code_valid);
        foreach (CG[k]) begin
            wreg(`IDX_CLK_GAIN, {2'b00, CG[k]});
            chk("clk gain", CG[k], clk_buf_gain);
            chk("clk ok", 1, clk_gain_code_valid);
        end
        wreg(`IDX_CLK_GAIN, 8'h21);
        chk("clk bad", 0, clk_gain_code_valid);
        for (int k = 0; k < 4; k += 1 + (k == 1)) begin
            wreg(`IDX_IFACE, 8'(k << 3));
            chk("cmos", k == 3, cmos_mode);
        end
        for (int k = 1; k < 8; k += 2) begin
            wreg(`IDX_REF_SCALE, 8'(k << 5 | (k & 2) << 3));
            chk("scale", k, power_scale);
            chk("ext ref", k >> 1 & 1, external_reference);
        end
    endtask
    task t_soft_reset;
        wreg(`IDX_GAIN, 8'h0B);
        pulses = 0;
        wreg(`IDX_IFACE, 8'h1A);
        tick(2);
        chk("reset pulse", 1, pulses);
        t_defaults();
    endtask

    initial begin
        {fails, checks_done, cycles, pulses} = '0;
        sample_in = 14'h2001;
        aresetn = 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        tick(1);
        t_defaults();
        t_unmapped();
        t_ctrl();
        t_patterns();
        t_fields();
        t_soft_reset();
        summarize();
    end
endmodule
